// *** amp_apb_host.sv ***
`timescale 1ns/10ps
module amp_apb_host (
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [amp_ctrl_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
   end
   // request stays put until pready is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no local limit: only the bench timeout may end a stalled access
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// *** amp_ctrl_pkg.sv ***
package amp_ctrl_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRL = 4'h1;
   localparam logic [3:0] IDX_HIZ = 4'h3;
   localparam logic [3:0] IDX_STATUS = 4'h5;
   localparam logic [3:0] IDX_IRQ_STAT = 4'h6;
   localparam logic [3:0] IDX_IRQ_EN = 4'h7;
   localparam logic [3:0] IDX_IRQ_CLR = 4'h8;
   localparam int ADDR_W = 8;

   // field positions
   localparam int BIT_STANDBY = 0;
   localparam int BIT_OVERTEMP = 1;
   localparam int BIT_HIZ_RIGHT = 0;
   localparam int BIT_HIZ_LEFT = 1;
   localparam int BIT_ST_COOL = 0;
   localparam int BIT_ST_FAULT = 1;
   localparam int BIT_ST_RAIL_HIGH = 2;
   localparam int BIT_ST_AMP_ON = 3;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_RECOVER = 1;
   localparam int IRQ_W = 2;

   // reset values
   localparam logic STANDBY_RESET = 1'b1;
   localparam logic [1:0] HIZ_RESET = 2'h0;
   localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 2'h0;

   // timing
   localparam int DISABLE_TIME_MS = 1000;
   localparam int CLK_MHZ = 125;
   localparam int DISABLE_CYCLES = DISABLE_TIME_MS * 1000 * CLK_MHZ;
   localparam int TIMER_W = 32;

   typedef enum logic [0:0] {
      TH_RUN = 1'b0,
      TH_COOL = 1'b1
   } overtemp_flag_state_t;

   function automatic logic [ADDR_W-1:0] byte_addr(input logic [3:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
endpackage

// *** amp_interval_timer.sv ***
`timescale 1ns/10ps
module amp_interval_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic [amp_ctrl_pkg::TIMER_W-1:0] load,
   // status
   output logic done
);
   logic [amp_ctrl_pkg::TIMER_W-1:0] count_q, count_d;
   logic done_q, done_d;

   always_comb begin
      count_d = count_q;
      done_d = 1'b0;
      if (start) begin
         count_d = load;
      end else if (count_q != '0) begin
         count_d = count_q - 1'b1;
         done_d = (count_q == 1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
         done_q <= 1'b0;
      end else begin
         count_q <= count_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;

   AST_TIMER_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
      start |=> count_q == $past(load))
      else $error("interval timer did not reload on start");
endmodule

// *** amp_protection_standby_ctrl.sv ***
`timescale 1ns/10ps
module amp_protection_standby_ctrl #(
   parameter int unsigned DISABLE_CYCLES = amp_ctrl_pkg::DISABLE_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [amp_ctrl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog monitors
   input wire logic overtemp_flag_fault_in,
   input wire logic amp_level_high_in,
   // power and output control
   output logic pos_rail_en,
   output logic neg_rail_en,
   output logic rail_high_sel,
   output logic amp_enable,
   output logic left_out_hiz,
   output logic right_out_hiz,
   // interrupt
   output logic irq
);
   logic fault_s, level_high_s;
   logic timer_done;
   amp_ctrl_pkg::overtemp_flag_state_t th_q, th_d;
   logic soft_standby_q, soft_standby_d;
   logic overtemp_flag_q, overtemp_flag_d;
   logic read_seen_q, read_seen_d;
   logic out_hiz_left_q, out_hiz_left_d;
   logic out_hiz_right_q, out_hiz_right_d;
   logic [amp_ctrl_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d;
   logic [amp_ctrl_pkg::IRQ_W-1:0] irq_en_q, irq_en_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic pos_rail_en_q, pos_rail_en_d;
   logic neg_rail_en_q, neg_rail_en_d;
   logic rail_high_q, rail_high_d;
   logic amp_enable_q, amp_enable_d;
   logic left_out_hiz_q, left_out_hiz_d;
   logic right_out_hiz_q, right_out_hiz_d;
   logic irq_q, irq_d;
   logic xfer_done, wr_done, rd_done, addr_ok, enter_cool, leave_cool;
   logic [amp_ctrl_pkg::IRQ_W-1:0] irq_set, irq_clr;

   amp_sync2 #(
      .W(2)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({overtemp_flag_fault_in, amp_level_high_in}),
      .q({fault_s, level_high_s})
   );

   amp_interval_timer u_timer (
      .clk(pclk),
      .rst_n(presetn),
      .start(enter_cool),
      .load(amp_ctrl_pkg::TIMER_W'(DISABLE_CYCLES)),
      .done(timer_done)
   );

   // apb decode; one wait state so every answer comes from a flop
   assign xfer_done = psel && penable && pready_q;
   assign wr_done = xfer_done && pwrite;
   assign rd_done = xfer_done && !pwrite;

   always_comb begin
      addr_ok = 1'b1;
      unique case (paddr)
         amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_CTRL),
         amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_HIZ),
         amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_STATUS),
         amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_IRQ_STAT),
         amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_IRQ_EN),
         amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_IRQ_CLR): addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   always_comb begin
      pready_d = psel && penable && !pready_q;
      pslverr_d = 1'b0;
      prdata_d = 32'h0000_0000;
      if (psel && penable && !pready_q) begin
         pslverr_d = !addr_ok;
         if (!pwrite) begin
            unique case (paddr)
               amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_CTRL): begin
                  prdata_d[amp_ctrl_pkg::BIT_STANDBY] = soft_standby_q;
                  prdata_d[amp_ctrl_pkg::BIT_OVERTEMP] = overtemp_flag_q;
               end
               amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_HIZ): begin
                  prdata_d[amp_ctrl_pkg::BIT_HIZ_LEFT] = out_hiz_left_q;
                  prdata_d[amp_ctrl_pkg::BIT_HIZ_RIGHT] = out_hiz_right_q;
               end
               amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_STATUS): begin
                  prdata_d[amp_ctrl_pkg::BIT_ST_COOL] = (th_q == amp_ctrl_pkg::TH_COOL);
                  prdata_d[amp_ctrl_pkg::BIT_ST_FAULT] = fault_s;
                  prdata_d[amp_ctrl_pkg::BIT_ST_RAIL_HIGH] = rail_high_q;
                  prdata_d[amp_ctrl_pkg::BIT_ST_AMP_ON] = amp_enable_q;
               end
               amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_IRQ_STAT):
                  prdata_d[amp_ctrl_pkg::IRQ_W-1:0] = irq_stat_q;
               amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_IRQ_EN):
                  prdata_d[amp_ctrl_pkg::IRQ_W-1:0] = irq_en_q;
               default: prdata_d = 32'h0000_0000;
            endcase
         end
      end
   end

   // software registers; the bus is never gated by standby
   always_comb begin
      soft_standby_d = soft_standby_q;
      out_hiz_left_d = out_hiz_left_q;
      out_hiz_right_d = out_hiz_right_q;
      irq_en_d = irq_en_q;
      irq_clr = '0;
      if (wr_done) begin
         unique case (paddr)
            amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_CTRL):
               soft_standby_d = pwdata[amp_ctrl_pkg::BIT_STANDBY];
            amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_HIZ): begin
               out_hiz_left_d = pwdata[amp_ctrl_pkg::BIT_HIZ_LEFT];
               out_hiz_right_d = pwdata[amp_ctrl_pkg::BIT_HIZ_RIGHT];
            end
            amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_IRQ_EN):
               irq_en_d = pwdata[amp_ctrl_pkg::IRQ_W-1:0];
            amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_IRQ_CLR):
               irq_clr = pwdata[amp_ctrl_pkg::IRQ_W-1:0];
            default: irq_clr = '0;
         endcase
      end
   end

   // thermal protection; standby suspends monitoring and ends any interval
   always_comb begin
      th_d = th_q;
      enter_cool = 1'b0;
      leave_cool = 1'b0;
      unique case (th_q)
         amp_ctrl_pkg::TH_RUN: begin
            if (fault_s && !soft_standby_q) begin
               th_d = amp_ctrl_pkg::TH_COOL;
               enter_cool = 1'b1;
            end
         end
         amp_ctrl_pkg::TH_COOL: begin
            if (soft_standby_q) begin
               th_d = amp_ctrl_pkg::TH_RUN;
            end else if (timer_done) begin
               th_d = amp_ctrl_pkg::TH_RUN;
               leave_cool = 1'b1;
            end
         end
      endcase
   end

   // flag needs a completed read and the fault gone; a new fault wins
   always_comb begin
      overtemp_flag_d = overtemp_flag_q;
      read_seen_d = read_seen_q;
      if (rd_done && overtemp_flag_q &&
          paddr == amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_CTRL)) begin
         read_seen_d = 1'b1;
      end
      if (read_seen_q && !fault_s) begin
         overtemp_flag_d = 1'b0;
         read_seen_d = 1'b0;
      end
      if (enter_cool) begin
         overtemp_flag_d = 1'b1;
         read_seen_d = 1'b0;
      end
   end

   // interrupt status: set beats clear
   assign irq_set = {leave_cool, enter_cool};
   always_comb begin
      irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
      irq_d = |(irq_stat_q & irq_en_q);
   end

   // output drive
   always_comb begin
      amp_enable_d = !soft_standby_q && th_q == amp_ctrl_pkg::TH_RUN;
      pos_rail_en_d = !soft_standby_q;
      neg_rail_en_d = !soft_standby_q;
      rail_high_d = amp_enable_d && level_high_s;
      left_out_hiz_d = out_hiz_left_q && amp_enable_d;
      right_out_hiz_d = out_hiz_right_q && amp_enable_d;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         th_q <= amp_ctrl_pkg::TH_RUN;
         soft_standby_q <= amp_ctrl_pkg::STANDBY_RESET;
         overtemp_flag_q <= 1'b0;
         read_seen_q <= 1'b0;
         {out_hiz_left_q, out_hiz_right_q} <= amp_ctrl_pkg::HIZ_RESET;
         irq_stat_q <= '0;
         irq_en_q <= amp_ctrl_pkg::IRQ_EN_RESET;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pos_rail_en_q <= 1'b0;
         neg_rail_en_q <= 1'b0;
         rail_high_q <= 1'b0;
         amp_enable_q <= 1'b0;
         left_out_hiz_q <= 1'b0;
         right_out_hiz_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         th_q <= th_d;
         soft_standby_q <= soft_standby_d;
         overtemp_flag_q <= overtemp_flag_d;
         read_seen_q <= read_seen_d;
         out_hiz_left_q <= out_hiz_left_d;
         out_hiz_right_q <= out_hiz_right_d;
         irq_stat_q <= irq_stat_d;
         irq_en_q <= irq_en_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         pos_rail_en_q <= pos_rail_en_d;
         neg_rail_en_q <= neg_rail_en_d;
         rail_high_q <= rail_high_d;
         amp_enable_q <= amp_enable_d;
         left_out_hiz_q <= left_out_hiz_d;
         right_out_hiz_q <= right_out_hiz_d;
         irq_q <= irq_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pos_rail_en = pos_rail_en_q;
   assign neg_rail_en = neg_rail_en_q;
   assign rail_high_sel = rail_high_q;
   assign amp_enable = amp_enable_q;
   assign left_out_hiz = left_out_hiz_q;
   assign right_out_hiz = right_out_hiz_q;
   assign irq = irq_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_cool_entry;
      th_q == amp_ctrl_pkg::TH_RUN && fault_s && !soft_standby_q;
   endsequence
   // standby may legally cut the interval, so hold only on what both keep off
   sequence s_cool_hold;
      (!amp_enable_q && !rail_high_q) [*4];
   endsequence

   AST_FAULT_DISABLES: assert property (s_cool_entry |=> overtemp_flag_q ##1 s_cool_hold)
      else $error("fault did not set flag and disable amplifier");
   AST_RETRY: assert property ((th_q == amp_ctrl_pkg::TH_COOL && timer_done)
         ##1 (fault_s && !soft_standby_q)
         |-> th_q == amp_ctrl_pkg::TH_RUN ##1 th_q == amp_ctrl_pkg::TH_COOL)
      else $error("interval did not retry while fault persists");
   AST_FLAG_HOLD: assert property (overtemp_flag_q && (!read_seen_q || fault_s) |=> overtemp_flag_q)
      else $error("overtemp flag cleared too early");
   AST_STANDBY_RAILS: assert property (soft_standby_q |=> !pos_rail_en_q && !neg_rail_en_q)
      else $error("rails on during standby");
   AST_STANDBY_NOMON: assert property (soft_standby_q |=> th_q == amp_ctrl_pkg::TH_RUN)
      else $error("thermal interval active in standby");
   AST_STANDBY_NOFLAG: assert property (soft_standby_q && !overtemp_flag_q |=> !overtemp_flag_q)
      else $error("flag set during standby");
   AST_STANDBY_KEEP: assert property (soft_standby_q && !wr_done |=>
         $stable(out_hiz_left_q) && $stable(irq_en_q) && soft_standby_q)
      else $error("register changed in standby without write");
   AST_HIZ_LEFT: assert property (out_hiz_left_q && !soft_standby_q &&
         th_q == amp_ctrl_pkg::TH_RUN |=> left_out_hiz_q)
      else $error("left output not high impedance");
   AST_HIZ_OVERRIDE: assert property (soft_standby_q || th_q == amp_ctrl_pkg::TH_COOL
         |=> !left_out_hiz_q && !right_out_hiz_q)
      else $error("hiz active in shutdown or protection");
   AST_RAIL_SEL: assert property (amp_enable_d |=> rail_high_q == $past(level_high_s))
      else $error("rail level does not follow amplitude");
   AST_STANDBY_ENTER: assert property (wr_done && pwdata[amp_ctrl_pkg::BIT_STANDBY] &&
         paddr == amp_ctrl_pkg::byte_addr(amp_ctrl_pkg::IDX_CTRL) |=> ##1 !amp_enable_q)
      else $error("standby write did not shut down");
endmodule

// *** amp_sync2.sv ***
`timescale 1ns/10ps
module amp_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // meta_q feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   localparam int DC = 40;
   logic pclk, presetn, link_clk, overtemp_flag_fault_in, amp_level_high_in;
   logic psel, penable, pwrite, pready, pslverr;
   logic [amp_ctrl_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic pos_rail_en, neg_rail_en, rail_high_sel, amp_enable;
   logic left_out_hiz, right_out_hiz, irq, e;
   int errors, tests_run, cycles, n;

   amp_protection_standby_ctrl #(.DISABLE_CYCLES(DC)) u_amp_protection_standby_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .overtemp_flag_fault_in(overtemp_flag_fault_in), .amp_level_high_in(amp_level_high_in),
      .pos_rail_en(pos_rail_en), .neg_rail_en(neg_rail_en), .rail_high_sel(rail_high_sel),
      .amp_enable(amp_enable), .left_out_hiz(left_out_hiz), .right_out_hiz(right_out_hiz),
      .irq(irq));
   amp_apb_host u_amp_apb_host (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // amplitude source, unrelated in phase to pclk
   initial begin
      link_clk = 1'b0;
      #37;
      forever #80 link_clk = ~link_clk;
   end

   task automatic print_verdict();
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      u_amp_apb_host.xfer(1'b1, idx, d, r, e);
   endtask
   task automatic rd(input logic [3:0] idx);
      u_amp_apb_host.xfer(1'b0, idx, 32'h0, r, e);
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic wait_amp(input logic lvl);
      n = 0;
      while (amp_enable !== lvl && n < 4000) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic t_reset_values();
      check({pos_rail_en, neg_rail_en, amp_enable, irq}, 0, "outputs after reset");
      rd(amp_ctrl_pkg::IDX_CTRL);
      check(r, 32'h1, "ctrl reset");
      rd(amp_ctrl_pkg::IDX_HIZ);
      check(r, 32'h0, "hiz reset");
      rd(amp_ctrl_pkg::IDX_IRQ_EN);
      check(r, 32'h0, "irq enable reset");
      rd(4'hf);
      check(r, 32'h0, "unmapped read data");
      check({31'h0, e}, 32'h1, "unmapped read error");
   endtask

   task automatic t_standby_hold();
      wr(amp_ctrl_pkg::IDX_HIZ, 32'h3);
      overtemp_flag_fault_in <= 1'b1;
      idle(30);
      rd(amp_ctrl_pkg::IDX_CTRL);
      check(r, 32'h1, "flag set in standby");
      rd(amp_ctrl_pkg::IDX_IRQ_STAT);
      check(r, 32'h0, "fault event in standby");
      rd(amp_ctrl_pkg::IDX_HIZ);
      check(r, 32'h3, "hiz kept in standby");
      check({left_out_hiz, right_out_hiz, pos_rail_en, neg_rail_en}, 0, "standby outs");
      overtemp_flag_fault_in <= 1'b0;
      idle(5);
   endtask

   task automatic t_run_hiz();
      wr(amp_ctrl_pkg::IDX_CTRL, 32'h0);
      idle(4);
      check({pos_rail_en, neg_rail_en, amp_enable}, 3'h7, "running");
      check({left_out_hiz, right_out_hiz}, 2'h3, "both hiz");
      wr(amp_ctrl_pkg::IDX_HIZ, 32'h2);
      idle(3);
      check({left_out_hiz, right_out_hiz}, 2'h2, "left hiz only");
      wr(amp_ctrl_pkg::IDX_HIZ, 32'h3);
   endtask

   task automatic t_rail();
      logic prev;
      n = 0;
      prev = rail_high_sel;
      repeat (200) begin
         @(posedge pclk);
         amp_level_high_in <= link_clk;
         if (rail_high_sel !== prev) n++;
         prev = rail_high_sel;
      end
      check(n >= 16, 1, "rail follows amplitude");
      amp_level_high_in <= 1'b1;
      idle(6);
      check(rail_high_sel, 1, "high rail");
      amp_level_high_in <= 1'b0;
      idle(6);
      check(rail_high_sel, 0, "low rail");
   endtask

   task automatic t_fault_cycle();
      wr(amp_ctrl_pkg::IDX_IRQ_EN, 32'h3);
      overtemp_flag_fault_in <= 1'b1;
      wait_amp(1'b0);
      check(n <= 8, 1, "fault disables");
      check({left_out_hiz, right_out_hiz, pos_rail_en}, 3'h1, "hiz overridden");
      overtemp_flag_fault_in <= 1'b0;
      wait_amp(1'b1);
      check(n >= DC - 2 && n <= DC + 6, 1, "disable length");
      check(irq, 1, "fault irq");
      rd(amp_ctrl_pkg::IDX_CTRL);
      check(r, 32'h2, "flag held until read");
      idle(4);
      rd(amp_ctrl_pkg::IDX_CTRL);
      check(r, 32'h0, "flag cleared after read");
   endtask

   task automatic t_retry();
      overtemp_flag_fault_in <= 1'b1;
      wait_amp(1'b0);
      check(n <= 8, 1, "fault disables again");
      rd(amp_ctrl_pkg::IDX_CTRL);
      check(r, 32'h2, "flag during fault");
      wr(amp_ctrl_pkg::IDX_IRQ_CLR, 32'h3);
      idle(2 * DC + 20);
      check(amp_enable, 0, "still disabled");
      rd(amp_ctrl_pkg::IDX_IRQ_STAT);
      check(r, 32'h3, "retry events");
      rd(amp_ctrl_pkg::IDX_CTRL);
      check(r, 32'h2, "flag while fault stays");
      overtemp_flag_fault_in <= 1'b0;
      wait_amp(1'b1);
      check(n <= DC + 8, 1, "recovers");
      idle(4);
      rd(amp_ctrl_pkg::IDX_CTRL);
      check(r, 32'h0, "flag cleared");
   endtask

   task automatic t_irq();
      wr(amp_ctrl_pkg::IDX_IRQ_EN, 32'h0);
      idle(3);
      check(irq, 0, "irq masked");
      wr(amp_ctrl_pkg::IDX_IRQ_EN, 32'h1);
      idle(3);
      check(irq, 1, "irq enabled");
      wr(amp_ctrl_pkg::IDX_IRQ_CLR, 32'h3);
      idle(3);
      check(irq, 0, "irq cleared");
      rd(amp_ctrl_pkg::IDX_IRQ_STAT);
      check(r, 32'h0, "status cleared");
   endtask

   task automatic t_standby_abort();
      overtemp_flag_fault_in <= 1'b1;
      wait_amp(1'b0);
      check(n <= 8, 1, "fault disables before standby");
      rd(amp_ctrl_pkg::IDX_STATUS);
      check(r, 32'h3, "status in interval");
      overtemp_flag_fault_in <= 1'b0;
      wr(amp_ctrl_pkg::IDX_CTRL, 32'h1);
      idle(3);
      check({pos_rail_en, neg_rail_en}, 2'h0, "rails off");
      wr(amp_ctrl_pkg::IDX_CTRL, 32'h0);
      idle(6);
      check(amp_enable, 1, "interval ended by standby");
   endtask

   initial begin
      presetn = 1'b0;
      overtemp_flag_fault_in = 1'b0;
      amp_level_high_in = 1'b0;
      errors = 0;
      tests_run = 0;
      cycles = 0;
      idle(16);
      presetn <= 1'b1;
      t_reset_values();
      t_standby_hold();
      t_run_hiz();
      t_rail();
      t_fault_cycle();
      t_retry();
      t_irq();
      t_standby_abort();
      print_verdict();
   end
endmodule
